//--- hw/acr_top.sv
// audio port clock routing: registers, divider and pin routing
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none
module acr_top
    import acr_pkg::*;
(
    // clock and reset
    input  wire logic                    clock,
    input  wire logic                    rst,
    // register bus
    input  wire logic [acr_pkg::ADDR_W-1:0] avs_address,
    input  wire logic                    avs_read,
    input  wire logic                    avs_write,
    input  wire logic [acr_pkg::DATA_W-1:0] avs_writedata,
    output var  logic [acr_pkg::DATA_W-1:0] avs_readdata,
    output logic                         avs_waitrequest,
    // source clock edge strobes for the divider
    input  wire logic                    pb_proc_edge,
    input  wire logic                    pb_mod_edge,
    input  wire logic                    rec_proc_edge,
    input  wire logic                    rec_mod_edge,
    // internal frame clocks and serial block output
    input  wire logic                    playback_frame_clock,
    input  wire logic                    record_frame_clock,
    input  wire logic                    si_dout,
    // primary pins and general pin one
    input  wire logic                    bclk_pin_i,
    output var  logic                    bclk_pin_o,
    output var  logic                    bclk_pin_oe_n,
    input  wire logic                    wclk_pin_i,
    output var  logic                    wclk_pin_o,
    output var  logic                    wclk_pin_oe_n,
    input  wire logic                    din_pin_i,
    input  wire logic                    dout_pin_i,
    output var  logic                    dout_pin_o,
    output var  logic                    dout_pin_oe_n,
    input  wire logic                    general_pin_one_i,
    // secondary outputs
    output var  logic                    sec_bclk_out,
    output var  logic                    sec_wclk_out,
    output var  logic                    sec_dout_out,
    // toward serial interface and clock generator
    output var  logic                    si_bclk,
    output var  logic                    si_wclk,
    output var  logic                    si_rec_wclk,
    output var  logic                    si_din,
    output var  logic                    clock_generator_bclk
);
    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic [REG_W-1:0] ifc_q;
    logic [REG_W-1:0] ifc2_q;
    logic [REG_W-1:0] div_q;
    logic [REG_W-1:0] sps_q;
    logic [REG_W-1:0] sir_q;
    logic [REG_W-1:0] sor_q;
    logic             done_q;
    logic             req;
    logic             accept;
    logic             wr_acc;
    logic [REG_W-1:0] wr_byte;
    logic [REG_W-1:0] rd_mux;
    logic [REG_W-1:0] status;
    logic [4:0]       pin_raw;
    logic [4:0]       pin_s;
    logic             bclk_s;
    logic             wclk_s;
    logic             din_s;
    logic             dout_s;
    logic             gpio_s;
    logic [2:0]       sb_src;
    logic [2:0]       sw_src;
    logic [1:0]       sd_src;
    logic [2:0]       rw_src;
    logic [1:0]       pw_sel;
    logic [1:0]       sw_sel;
    logic [1:0]       bdiv_sel;
    logic             sec_bclk;
    logic             sec_wclk;
    logic             sec_din;
    logic             sec_rwclk;
    logic             gen_bclk;
    logic             in_bclk;
    logic             in_wclk;
    logic             rec_wclk;
    logic             in_din;
    logic             pb_o;
    logic             pw_o;
    logic             sb_o;
    logic             sw_o;
    logic             pd_o;
    logic             sd_o;
    logic             dout_in_use;
    logic             div_tick;

    acr_div_if dvi ();

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    assign pin_raw = {general_pin_one_i, dout_pin_i, din_pin_i,
                      wclk_pin_i, bclk_pin_i};

    acr_sync #(
        .WIDTH (5)
    ) u_sync (
        .clock    (clock),
        .rst      (rst),
        .async_in (pin_raw),
        .sync_out (pin_s)
    );

    assign bclk_s = pin_s[0];
    assign wclk_s = pin_s[1];
    assign din_s  = pin_s[2];
    assign dout_s = pin_s[3];
    assign gpio_s = pin_s[4];

    // ----------------------------------------------------------------
    // register bus: one wait state per access
    // ----------------------------------------------------------------
    assign req             = avs_read | avs_write;
    assign accept          = req & done_q;
    assign wr_acc          = avs_write & done_q;
    assign wr_byte         = avs_writedata[REG_W-1:0];
    assign avs_waitrequest = req & ~done_q;

    always_ff @(posedge clock)
    begin
        if (rst)
            done_q <= 1'b0;
        else
            done_q <= req & ~done_q;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            ifc_q  <= RST_ZERO;
            ifc2_q <= RST_ZERO;
            div_q  <= RST_DIV;  // see RQ1
            sps_q  <= RST_ZERO;
            sir_q  <= RST_ZERO;
            sor_q  <= RST_ZERO;
        end
        else if (wr_acc)
        begin
            case (avs_address)
                ADDR_IFC:  ifc_q  <= wr_byte;
                ADDR_IFC2: ifc2_q <= wr_byte;
                ADDR_DIV:  div_q  <= wr_byte;
                ADDR_SPS:  sps_q  <= wr_byte;
                ADDR_SIR:  sir_q  <= wr_byte;
                ADDR_SOR:  sor_q  <= wr_byte;
                default:   ;
            endcase
        end
    end

    assign status = {3'h0, dout_in_use, sec_wclk, sec_bclk,
                     gen_bclk, dvi.running};

    always_comb
    begin
        case (avs_address)
            ADDR_IFC:  rd_mux = ifc_q;
            ADDR_IFC2: rd_mux = ifc2_q;
            ADDR_DIV:  rd_mux = div_q;
            ADDR_SPS:  rd_mux = sps_q;
            ADDR_SIR:  rd_mux = sir_q;
            ADDR_SOR:  rd_mux = sor_q;
            ADDR_STAT: rd_mux = status;
            default:   rd_mux = RST_ZERO;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            avs_readdata <= '0;
        else if (avs_read && !done_q)
            avs_readdata <= {{(DATA_W-REG_W){1'b0}}, rd_mux};
    end

    // ----------------------------------------------------------------
    // bit clock divider
    // ----------------------------------------------------------------
    assign bdiv_sel = ifc2_q[IFC2_BDIV_LSB +: 2];
    assign div_tick = (bdiv_sel == BDIV_PB_PROC)  ? pb_proc_edge  :
                      (bdiv_sel == BDIV_PB_MOD)   ? pb_mod_edge   :
                      (bdiv_sel == BDIV_REC_PROC) ? rec_proc_edge :
                                                    rec_mod_edge;
                                                    // see RQ17
    assign dvi.enable = div_q[DIV_EN];               // see RQ1
    assign dvi.ratio  = div_q[RATIO_W-1:0];          // see RQ2
    assign dvi.tick   = div_tick;

    acr_bdiv u_bdiv (
        .clock (clock),
        .rst   (rst),
        .dv    (dvi.div)
    );

    // ----------------------------------------------------------------
    // secondary sources; reserved codes give a low level
    // ----------------------------------------------------------------
    assign sb_src    = sps_q[SPS_BCLK_LSB +: 3];
    assign sw_src    = sps_q[SPS_WCLK_LSB +: 3];
    assign sd_src    = sps_q[SPS_DIN_LSB +: 2];
    assign rw_src    = sir_q[SIR_REC_LSB +: 3];
    assign sec_bclk  = (sb_src == PIN_GPIO) ? gpio_s :
                       (sb_src == PIN_DOUT) ? dout_s : 1'b0; // see RQ3
    assign sec_wclk  = (sw_src == PIN_GPIO) ? gpio_s :
                       (sw_src == PIN_DOUT) ? dout_s : 1'b0; // see RQ4
    assign sec_din   = (sd_src == DIN_GPIO) & gpio_s;        // see RQ5
    assign sec_rwclk = (rw_src == PIN_GPIO) & gpio_s;        // see RQ6
    assign dout_in_use = (sb_src == PIN_DOUT) | (sw_src == PIN_DOUT);

    // ----------------------------------------------------------------
    // inward selection
    // ----------------------------------------------------------------
    assign gen_bclk = dvi.bclk ^ ifc2_q[IFC2_BCLK_INV];   // see RQ20
    assign in_bclk  = (sir_q[SIR_BCLK_SEL] ? sec_bclk : bclk_s)
                      ^ ifc2_q[IFC2_BCLK_INV];            // see RQ7
    assign in_wclk  = sir_q[SIR_WCLK_SEL] ? sec_wclk : wclk_s; // see RQ8
    assign rec_wclk = sir_q[SIR_REC_SEL] ? sec_rwclk : in_wclk; // see RQ9
    assign in_din   = sir_q[SIR_DIN_SEL] ? sec_din : din_s; // see RQ10

    // ----------------------------------------------------------------
    // outward selection
    // ----------------------------------------------------------------
    assign pw_sel = sor_q[SOR_PW_LSB +: 2];
    assign sw_sel = sor_q[SOR_SW_LSB +: 2];
    assign pb_o   = sor_q[SOR_PB_OUT] ? sec_bclk : gen_bclk; // see RQ11
    assign sb_o   = sor_q[SOR_SB_OUT] ? gen_bclk : bclk_s;   // see RQ12
    assign pw_o   = (pw_sel == PW_PLAY) ? playback_frame_clock :
                    (pw_sel == PW_REC)  ? record_frame_clock   :
                    (pw_sel == PW_SEC)  ? sec_wclk : 1'b0;   // see RQ13
    assign sw_o   = (sw_sel == SW_PRIM) ? wclk_s               :
                    (sw_sel == SW_PLAY) ? playback_frame_clock :
                    (sw_sel == SW_REC)  ? record_frame_clock   :
                                          1'b0;              // see RQ14
    assign pd_o   = sor_q[SOR_PD_OUT] ? sec_din : si_dout;   // see RQ15
    assign sd_o   = sor_q[SOR_SD_OUT] ? si_dout : din_s;     // see RQ16

    // ----------------------------------------------------------------
    // registered pin and block outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            bclk_pin_o    <= 1'b0;
            bclk_pin_oe_n <= 1'b1;
            wclk_pin_o    <= 1'b0;
            wclk_pin_oe_n <= 1'b1;
            dout_pin_o    <= 1'b0;
            dout_pin_oe_n <= 1'b0;
            sec_bclk_out  <= 1'b0;
            sec_wclk_out  <= 1'b0;
            sec_dout_out  <= 1'b0;
        end
        else
        begin
            bclk_pin_o    <= pb_o;
            bclk_pin_oe_n <= ~ifc_q[IFC_BCLK_DIR]; // see RQ18
            wclk_pin_o    <= pw_o;
            wclk_pin_oe_n <= ~ifc_q[IFC_WCLK_DIR]; // see RQ19
            dout_pin_o    <= pd_o;
            dout_pin_oe_n <= dout_in_use;
            sec_bclk_out  <= sb_o;
            sec_wclk_out  <= sw_o;
            sec_dout_out  <= sd_o;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            si_bclk              <= 1'b0;
            si_wclk              <= 1'b0;
            si_rec_wclk          <= 1'b0;
            si_din               <= 1'b0;
            clock_generator_bclk <= 1'b0;
        end
        else
        begin
            si_bclk              <= in_bclk;
            si_wclk              <= in_wclk;
            si_rec_wclk          <= rec_wclk;
            si_din               <= in_din;
            clock_generator_bclk <= in_bclk; // see RQ7
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    sequence s_req_wait;
        req && !done_q && avs_waitrequest;
    endsequence

    sequence s_req_done;
        !avs_waitrequest;
    endsequence

    bus_wait_a: assert property (s_req_wait |=> s_req_done)
        else $error("waitrequest did not fall after one wait state");

    div_write_a: assert property (
        wr_acc && avs_address == ADDR_DIV
        |=> div_q == $past(wr_byte)) // see RQ1
        else $error("divider register did not take the write");

    div_off_a: assert property (
        !div_q[DIV_EN] |-> !dvi.running ##1 !dvi.bclk) // see RQ21
        else $error("divider output not static while powered down");

    ratio_128_a: assert property (
        div_q[DIV_EN] && dvi.ratio == '0 && $stable(div_q)
        && dvi.tick && dvi.bclk != $past(dvi.bclk)
        |=> dvi.bclk == $past(dvi.bclk)) // see RQ2
        else $error("code zero divider toggled on consecutive edges");

    sec_bclk_a: assert property (
        sb_src == PIN_DOUT && !sor_q[SOR_PB_OUT] == 1'b0
        |=> bclk_pin_o == $past(dout_s)) // see RQ3
        else $error("primary bit clock does not follow data-out pin");

    sec_din_a: assert property (
        sor_q[SOR_PD_OUT] && sd_src == DIN_GPIO
        |=> dout_pin_o == $past(gpio_s)) // see RQ15
        else $error("primary data out does not carry secondary input");

    wclk_rsvd_a: assert property (
        pw_sel == 2'h3 |=> !wclk_pin_o) // see RQ13
        else $error("reserved word clock code drives a level");

    sec_wclk_out_a: assert property ( // see RQ14
        sw_sel == SW_REC |=> sec_wclk_out == $past(record_frame_clock))
        else $error("secondary word clock not record frame clock");

    rec_wclk_a: assert property (
        !sir_q[SIR_REC_SEL] |=> si_rec_wclk == si_wclk) // see RQ9
        else $error("record word clock differs from playback one");

    bclk_dir_a: assert property (
        $rose(ifc_q[IFC_BCLK_DIR]) |=> !bclk_pin_oe_n) // see RQ18
        else $error("bit clock pin not driven after direction set");

    din_sel_a: assert property (
        sir_q[SIR_DIN_SEL] && $stable(sir_q)
        |=> si_din == $past(sec_din)) // see RQ10
        else $error("serial block input not secondary data");

    sb_out_a: assert property (
        sor_q[SOR_SB_OUT] |=> sec_bclk_out == $past(gen_bclk)) // see RQ12
        else $error("secondary bit clock out not internal clock");

endmodule
`default_nettype wire

//--- hw/acr_pkg.sv
// constants for the audio port clock routing block
// Operation
// RQ1: divider enable bit powers divider; reset off
// RQ2: ratio field equals value; zero means 128
// RQ3: secondary bit clock from pin one or data-out
// RQ4: secondary word clock from pin one or data-out
// RQ5: secondary data input code 00 uses pin one
// RQ6: record word clock code 000 uses pin one
// RQ7: select primary or secondary bit clock inward
// RQ8: select primary or secondary word clock inward
// RQ9: record word clock is playback or separate
// RQ10: select primary or secondary data input inward
// RQ11: primary bit clock out: internal or secondary
// RQ12: secondary bit clock out: primary or internal
// RQ13: primary word clock out: playback, record, secondary
// RQ14: secondary word clock out: primary, playback, record
// RQ15: primary data out: serial block or secondary
// RQ16: secondary data out: primary input or serial
// RQ17: divider input chosen from four source clocks
// RQ18: bit clock pin direction bit
// RQ19: word clock pin direction bit
// RQ20: inversion bit inverts both bit clocks
// RQ21: divider output is input over ratio, else static
// RQ22: software avoids reserved selector codes
package acr_pkg;

    // ----------------------------------------------------------------
    // register indices and byte addresses
    // ----------------------------------------------------------------
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    localparam int          REG_W         = 8;
    localparam logic [7:0]  IDX_IFC       = 8'h1B;
    localparam logic [7:0]  IDX_IFC2      = 8'h1D;
    localparam logic [7:0]  IDX_DIV       = 8'h1E;
    localparam logic [7:0]  IDX_SPS       = 8'h1F;
    localparam logic [7:0]  IDX_SIR       = 8'h20;
    localparam logic [7:0]  IDX_SOR       = 8'h21;
    localparam logic [7:0]  IDX_STAT      = 8'h3F;
    localparam logic [7:0]  ADDR_IFC      = 8'(IDX_IFC * 4);
    localparam logic [7:0]  ADDR_IFC2     = 8'(IDX_IFC2 * 4);
    localparam logic [7:0]  ADDR_DIV      = 8'(IDX_DIV * 4);
    localparam logic [7:0]  ADDR_SPS      = 8'(IDX_SPS * 4);
    localparam logic [7:0]  ADDR_SIR      = 8'(IDX_SIR * 4);
    localparam logic [7:0]  ADDR_SOR      = 8'(IDX_SOR * 4);
    localparam logic [7:0]  ADDR_STAT     = 8'(IDX_STAT * 4);

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0]  RST_DIV       = 8'h01;
    localparam logic [7:0]  RST_ZERO      = 8'h00;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int          DIV_EN        = 7;
    localparam int          RATIO_W       = 7;
    localparam int          SPS_BCLK_LSB  = 5;
    localparam int          SPS_WCLK_LSB  = 2;
    localparam int          SPS_DIN_LSB   = 0;
    localparam int          SIR_REC_LSB   = 5;
    localparam int          SIR_BCLK_SEL  = 3;
    localparam int          SIR_WCLK_SEL  = 2;
    localparam int          SIR_REC_SEL   = 1;
    localparam int          SIR_DIN_SEL   = 0;
    localparam int          SOR_PB_OUT    = 7;
    localparam int          SOR_SB_OUT    = 6;
    localparam int          SOR_PW_LSB    = 4;
    localparam int          SOR_SW_LSB    = 2;
    localparam int          SOR_PD_OUT    = 1;
    localparam int          SOR_SD_OUT    = 0;
    localparam int          IFC_BCLK_DIR  = 3;
    localparam int          IFC_WCLK_DIR  = 2;
    localparam int          IFC2_BCLK_INV = 3;
    localparam int          IFC2_BDIV_LSB = 0;

    // ----------------------------------------------------------------
    // selector codes
    // ----------------------------------------------------------------
    localparam logic [2:0]  PIN_GPIO      = 3'h0;
    localparam logic [2:0]  PIN_DOUT      = 3'h3;
    localparam logic [1:0]  DIN_GPIO      = 2'h0;
    localparam logic [1:0]  PW_PLAY       = 2'h0;
    localparam logic [1:0]  PW_REC        = 2'h1;
    localparam logic [1:0]  PW_SEC        = 2'h2;
    localparam logic [1:0]  SW_PRIM       = 2'h0;
    localparam logic [1:0]  SW_PLAY       = 2'h1;
    localparam logic [1:0]  SW_REC        = 2'h2;
    localparam logic [1:0]  BDIV_PB_PROC  = 2'h0;
    localparam logic [1:0]  BDIV_PB_MOD   = 2'h1;
    localparam logic [1:0]  BDIV_REC_PROC = 2'h2;
    localparam logic [1:0]  BDIV_REC_MOD  = 2'h3;
    localparam logic [7:0]  RATIO_ZERO_N  = 8'h80;

endpackage

//--- hw/acr_div_if.sv
// carrier between the register side and the bit clock divider
`timescale 1ns/100ps
`default_nettype none
interface acr_div_if;
    logic       enable;
    logic [6:0] ratio;
    logic       tick;
    logic       bclk;
    logic       running;

    modport ctl (output enable, output ratio, output tick,
                 input bclk, input running);
    modport div (input enable, input ratio, input tick,
                 output bclk, output running);
endinterface
`default_nettype wire

//--- hw/acr_sync.sv
// two flip-flop synchroniser bank for pin inputs
`timescale 1ns/100ps
`default_nettype none
module acr_sync #(
    parameter int WIDTH = 5
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             rst,
    // levels
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    initial
    begin
        if (WIDTH < 1)
            $error("acr_sync: WIDTH must be at least 1");
    end

    // ----------------------------------------------------------------
    // one synchroniser per bit
    // ----------------------------------------------------------------
    for (genvar i = 0; i < WIDTH; i++)
    begin : g_bit
        always_ff @(posedge clock)
        begin
            if (rst)
            begin
                meta_q[i]   <= 1'b0;
                sync_out[i] <= 1'b0;
            end
            else
            begin
                meta_q[i]   <= async_in[i];
                sync_out[i] <= meta_q[i];
            end
        end
    end
endmodule
`default_nettype wire

//--- hw/acr_bdiv.sv
// programmable divide-by-n bit clock divider
`timescale 1ns/100ps
`default_nettype none
module acr_bdiv
    import acr_pkg::*;
(
    // clock and reset
    input  wire logic clock,
    input  wire logic rst,
    // control and output
    acr_div_if.div    dv
);
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic [7:0] ratio_n;
    logic       last_edge;
    logic       bclk_q;

    // code zero selects 128, others their own value
    assign ratio_n   = (dv.ratio == '0) ? RATIO_ZERO_N
                                        : {1'b0, dv.ratio}; // see RQ2
    assign last_edge = (cnt_q == 8'(ratio_n - 8'h01));
    assign cnt_d     = last_edge ? 8'h00 : 8'(cnt_q + 8'h01);
    assign dv.bclk    = bclk_q;
    assign dv.running = dv.enable;

    // ----------------------------------------------------------------
    // divider: one output edge every ratio source edges
    // ----------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (rst || !dv.enable)
        begin
            cnt_q  <= 8'h00;  // see RQ1
            bclk_q <= 1'b0;   // see RQ21
        end
        else if (dv.tick)
        begin
            cnt_q <= cnt_d;
            if (last_edge)
                bclk_q <= ~bclk_q; // see RQ21
        end
    end
endmodule
`default_nettype wire

//--- dv/acr_far.sv
// far audio device model that drives the primary and general pins
`timescale 1ns/100ps
`default_nettype none
module acr_far (
    // clock
    input  wire logic       clock,
    // wanted levels: bit clock, word clock, data in, data out, pin one
    input  wire logic [4:0] want,
    output var  logic [4:0] pins
);
    // the far side moves its pins just after a rising edge
    always_ff @(posedge clock)
    begin
        pins <= want;
    end
endmodule
`default_nettype wire

//--- dv/acr_top_test.sv
// self-checking bench for the audio port clock routing block
`timescale 1ns/100ps
`default_nettype none
module acr_top_test;
    import acr_pkg::*;
    logic        clock, wq, bo, bn, wo, wn, dn, dout_o, cg;
    logic        rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, edg = 1'b0;
    logic [7:0]  avs_address = 8'h00, r;
    logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata;
    logic [2:0]  lvl = 3'h0, sec;
    logic [3:0]  si;
    logic [4:0]  want = 5'h00, pins;
    int          errors = 0, check_count = 0, n;
    wire         bclk_w = bn ? pins[4] : bo;
    wire         wclk_w = wn ? pins[3] : wo;
    wire         dout_w = dn ? pins[1] : dout_o;
    acr_top dut_u (.clock, .rst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest(wq),
        .pb_proc_edge(edg), .pb_mod_edge(edg), .rec_proc_edge(edg),
        .rec_mod_edge(edg), .playback_frame_clock(lvl[2]),
        .record_frame_clock(lvl[1]), .si_dout(lvl[0]), .bclk_pin_i(bclk_w),
        .bclk_pin_o(bo), .bclk_pin_oe_n(bn), .wclk_pin_i(wclk_w),
        .wclk_pin_o(wo), .wclk_pin_oe_n(wn), .din_pin_i(pins[2]),
        .dout_pin_i(dout_w), .dout_pin_o(dout_o), .dout_pin_oe_n(dn),
        .general_pin_one_i(pins[0]), .sec_bclk_out(sec[2]),
        .sec_wclk_out(sec[1]), .sec_dout_out(sec[0]), .si_bclk(si[3]),
        .si_wclk(si[2]), .si_rec_wclk(si[1]), .si_din(si[0]),
        .clock_generator_bclk(cg));
    acr_far far_u (.clock, .want, .pins);
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] exp, got);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic checkb(input string what, input logic exp, got);
        check(what, {7'h00, exp}, {7'h00, got});
    endtask
    task automatic bus(input logic w, input logic [7:0] a, d);
        @(posedge clock);
        avs_address   <= a;
        avs_writedata <= {24'h00_0000, d};
        avs_write     <= w;
        avs_read      <= !w;
        do
            @(posedge clock);
        while (wq !== 1'b0);
        r = avs_readdata[7:0];
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic settle;
        repeat (6) @(posedge clock);
        @(negedge clock);
    endtask
    task automatic half(output int cnt);
        logic s;
        s = sec[2];
        cnt = 0;
        do
        begin
            @(negedge clock);
            cnt++;
        end
        while (sec[2] === s && cnt < 200);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        bus(0, ADDR_DIV, 8'h00);
        check("divider", RST_DIV, r);
        bus(0, ADDR_SPS, 8'h00);
        check("pin source", RST_ZERO, r);
        bus(0, ADDR_SIR, 8'h00);
        check("input routing", RST_ZERO, r);
        bus(1, ADDR_SOR, 8'hA5);
        bus(0, ADDR_SOR, 8'h00);
        check("output routing", 8'hA5, r);
        bus(0, 8'h00, 8'h00);
        check("unmapped", 8'h00, r);
    endtask
    task automatic t_route;
        bus(1, ADDR_SOR, 8'h80);
        for (int k = 0; k < 2; k++)
        begin
            @(posedge clock);
            want <= k[0] ? 5'h14 : 5'h0B;
            settle;
            checkb("sec bclk out", want[4], sec[2]);
            checkb("sec wclk out", want[3], sec[1]);
            checkb("sec dout", want[2], sec[0]);
            checkb("si bclk", want[4], si[3]);
            checkb("si wclk", want[3], si[2]);
            checkb("si rec wclk", want[3], si[1]);
            checkb("si din", want[2], si[0]);
        end
        bus(1, ADDR_SIR, 8'h0F);
        for (int k = 0; k < 2; k++)
        begin
            @(posedge clock);
            want <= k[0] ? 5'h01 : 5'h1E;
            settle;
            checkb("sec bclk in", want[0], si[3]);
            checkb("sec wclk in", want[0], si[2]);
            checkb("rec wclk in", want[0], si[1]);
            checkb("sec din in", want[0], si[0]);
            checkb("cg", want[0], cg);
        end
        bus(1, ADDR_SPS, 8'h6C);
        @(posedge clock);
        want <= 5'h02;
        settle;
        checkb("dout as bclk", 1'b1, si[3]);
        checkb("dout as wclk", 1'b1, si[2]);
        checkb("pin one rec wclk", 1'b0, si[1]);
        checkb("dn", 1'b1, dn);
        bus(1, ADDR_SPS, 8'h00);
        bus(1, ADDR_IFC, 8'h0C);
        bus(1, ADDR_SOR, 8'hA2);
        @(posedge clock);
        want <= 5'h01;
        lvl <= 3'h3;
        settle;
        checkb("bclk dir", 1'b0, bn);
        checkb("wclk dir", 1'b0, wn);
        checkb("bclk pin", 1'b1, bo);
        checkb("wclk pin sec", 1'b1, wo);
        checkb("dout pin sec", 1'b1, dout_o);
        bus(1, ADDR_SOR, 8'h15);
        settle;
        checkb("wclk pin rec", 1'b1, wo);
        checkb("sec wclk play", 1'b0, sec[1]);
        checkb("dout pin serial", 1'b1, dout_o);
        checkb("sec dout serial", 1'b1, sec[0]);
        checkb("bclk pin idle", 1'b0, bo);
        bus(1, ADDR_SOR, 8'h08);
        settle;
        checkb("wclk pin play", 1'b0, wo);
        checkb("sec wclk rec", 1'b1, sec[1]);
    endtask
    task automatic t_div;
        bus(1, ADDR_SOR, 8'h40);
        edg <= 1'b1;
        bus(1, ADDR_DIV, 8'h83);
        half(n);
        half(n);
        check("ratio three", 8'h03, n[7:0]);
        bus(1, ADDR_DIV, 8'h80);
        half(n);
        half(n);
        check("ratio zero", RATIO_ZERO_N, n[7:0]);
        bus(1, ADDR_DIV, 8'h03);
        bus(1, ADDR_IFC2, 8'h08);
        settle;
        checkb("off inverted", 1'b1, sec[2]);
        half(n);
        check("off static", 8'hC8, n[7:0]);
    endtask
    task automatic complete_run;
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    initial
    begin
        repeat (20000) @(posedge clock);
        errors++;
        complete_run;
    end
    initial
    begin
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        t_regs;
        t_route;
        t_div;
        complete_run;
    end
endmodule
`default_nettype wire
